// >>> sxc_pkg.sv
package sxc_pkg;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_OPCODE   = 8'h04;
    localparam logic [7:0] OFF_CDW10    = 8'h08;
    localparam logic [7:0] OFF_CDW11    = 8'h0c;
    localparam logic [7:0] OFF_PTR1_LO  = 8'h10;
    localparam logic [7:0] OFF_PTR1_HI  = 8'h14;
    localparam logic [7:0] OFF_PTR2_LO  = 8'h18;
    localparam logic [7:0] OFF_PTR2_HI  = 8'h1c;
    localparam logic [7:0] OFF_STATUS   = 8'h20;
    localparam logic [7:0] OFF_CPL      = 8'h24;
    localparam logic [7:0] OFF_ADDR_LO  = 8'h28;
    localparam logic [7:0] OFF_ADDR_HI  = 8'h2c;
    localparam logic [7:0] OFF_WIN_IDX  = 8'h30;
    localparam logic [7:0] OFF_WIN_DATA = 8'h34;

    localparam logic [7:0] OPC_FORMAT   = 8'h80;
    localparam logic [7:0] OPC_SEC_SEND = 8'h81;
    localparam logic [7:0] OPC_SEC_RECV = 8'h82;

    localparam logic [7:0] ST_SUCCESS   = 8'h00;
    localparam logic [7:0] ST_INV_PARAM = 8'h02;
    localparam logic [7:0] ST_INV_FMT   = 8'h0a;
    localparam logic [7:0] PROTO_DISC   = 8'h00;

    localparam int CTRL_GO      = 0;
    localparam int CTRL_DISCARD = 1;
    localparam int CPL_VALID    = 31;
    localparam int FMT_MS_BIT   = 4;
    localparam int PAGE_BYTES   = 4096;
    localparam int PI_BYTES     = 8;
    localparam int FORMAT_TIME_US = 40;
    localparam int CLK_MHZ      = 25;
    localparam int FORMAT_CYCLES = FORMAT_TIME_US * CLK_MHZ;

    typedef enum logic [3:0] {
        SXC_IDLE = 4'b0001,
        SXC_FMT  = 4'b0010,
        SXC_XFER = 4'b0100,
        SXC_POST = 4'b1000
    } sxc_state_e;
endpackage

// >>> sxc_mem_if.sv
`timescale 1ns/1ps
interface sxc_mem_if #(parameter int AW = 6, parameter int DW = 32);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// >>> sxc_buf_mem.sv
`timescale 1ns/1ps
module sxc_buf_mem #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input  wire logic aclk,
    sxc_mem_if.mem    port
);
    logic [DW-1:0] store [2**AW];

    // Read data registered; write-first is not needed here
    always_ff @(posedge aclk)
    begin
        if (port.en)
        begin
            if (port.we)
                store[port.addr] <= port.wdata;
            port.rdata <= store[port.addr];
        end
    end
endmodule

// >>> sxc_cmd_handler.sv
`timescale 1ns/1ps
module sxc_cmd_handler #(
    parameter int            BUF_AW      = 6,
    parameter int            NUM_FORMATS = 2,
    parameter logic [255:0]  FMT_META    = {240'h0, 8'h08, 8'h00},
    parameter int            NUM_PROTO   = 2,
    parameter logic [63:0]   PROTO_LIST  = {48'h0, 8'h02, 8'h01}
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    localparam int BUF_DEPTH = 2**BUF_AW;

    typedef struct packed {
        sxc_pkg::sxc_state_e state;
        logic                awready;
        logic                wready;
        logic                arready;
        logic [7:0]          aw_addr;
        logic [31:0]         w_data;
        logic                bvalid;
        logic [1:0]          bresp;
        logic [1:0]          rd_stage;
        logic [7:0]          ar_addr;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [7:0]          opcode;
        logic [31:0]         cdw10;
        logic [31:0]         cdw11;
        logic [63:0]         ptr1;
        logic [63:0]         ptr2;
        logic [31:0]         cpl;
        logic [7:0]          code;
        logic                disc;
        logic                pend_valid;
        logic [7:0]          pend_proto;
        logic [15:0]         pend_protocol_specific_param;
        logic [31:0]         pend_len;
        logic [BUF_AW-1:0]   win_idx;
        logic [31:0]         cnt;
        logic [31:0]         limit;
        logic [63:0]         last_addr;
    } sxc_regs_s;

    sxc_regs_s st;
    sxc_regs_s next_st;
    sxc_mem_if #(.AW(BUF_AW), .DW(32)) mem ();

    sxc_buf_mem #(.AW(BUF_AW), .DW(32)) u_mem (
        .aclk (aclk),
        .port (mem)
    );

    function automatic logic proto_ok(input logic [7:0] p);
        logic ok;
        ok = (p == sxc_pkg::PROTO_DISC);
        for (int i = 0; i < NUM_PROTO; i++)
            if (PROTO_LIST[i*8 +: 8] == p)
                ok = 1'b1;
        return ok;
    endfunction

    // Bytes left in the first page; past that the second pointer is used raw
    function automatic logic [63:0] seg_addr(input logic [63:0] p1, input logic [63:0] p2,
                                              input logic [31:0] off);
        logic [31:0] first;
        first = 32'(sxc_pkg::PAGE_BYTES) - {20'h0, p1[11:0]};
        if (off < first)
            return p1 + {32'h0, off};
        return p2 + {32'h0, off - first};
    endfunction

    function automatic logic [31:0] min32(input logic [31:0] a, input logic [31:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [7:0] meta_of(input logic [3:0] f);
        return FMT_META[{4'h0, f} * 8 +: 8];
    endfunction

    logic [31:0] rd_mux;
    logic [31:0] wr_q;
    logic [31:0] w_in;
    logic        wr_fire;
    logic [7:0]  sel_proto;
    logic [3:0]  sel_fmt;

    assign sel_proto = st.cdw10[31:24];
    assign sel_fmt   = st.cdw10[3:0];

    always_comb
    begin
        case (st.ar_addr)
            sxc_pkg::OFF_OPCODE:   rd_mux = {24'h0, st.opcode};
            sxc_pkg::OFF_CDW10:    rd_mux = st.cdw10;
            sxc_pkg::OFF_CDW11:    rd_mux = st.cdw11;
            sxc_pkg::OFF_PTR1_LO:  rd_mux = st.ptr1[31:0];
            sxc_pkg::OFF_PTR1_HI:  rd_mux = st.ptr1[63:32];
            sxc_pkg::OFF_PTR2_LO:  rd_mux = st.ptr2[31:0];
            sxc_pkg::OFF_PTR2_HI:  rd_mux = st.ptr2[63:32];
            sxc_pkg::OFF_STATUS:   rd_mux = {30'h0, st.pend_valid, st.state != sxc_pkg::SXC_IDLE};
            sxc_pkg::OFF_CPL:      rd_mux = st.cpl;
            sxc_pkg::OFF_ADDR_LO:  rd_mux = st.last_addr[31:0];
            sxc_pkg::OFF_ADDR_HI:  rd_mux = st.last_addr[63:32];
            sxc_pkg::OFF_WIN_IDX:  rd_mux = 32'(st.win_idx);
            sxc_pkg::OFF_WIN_DATA: rd_mux = mem.rdata;
            default:               rd_mux = 32'h0;
        endcase
    end

    assign wr_fire = !st.awready && !st.wready && !st.bvalid;
    // Strobes belong to the data beat, so lanes are masked when the beat is taken
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            w_in[b*8 +: 8] = s_wstrb[b] ? s_wdata[b*8 +: 8] : 8'h00;
    end
    assign wr_q = st.w_data;

    always_comb
    begin
        next_st = st;
        mem.en = 1'b0;
        mem.we = 1'b0;
        mem.addr = st.win_idx;
        mem.wdata = st.w_data;
        // Address and data are taken in either order
        if (s_awvalid && st.awready)
        begin
            next_st.awready = 1'b0;
            next_st.aw_addr = s_awaddr;
        end
        if (s_wvalid && st.wready)
        begin
            next_st.wready = 1'b0;
            next_st.w_data = w_in;
        end
        if (st.bvalid && s_bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        if (wr_fire)
        begin
            next_st.bvalid = 1'b1;
            next_st.bresp = 2'b00;
            case (st.aw_addr)
                sxc_pkg::OFF_OPCODE:  next_st.opcode = wr_q[7:0];
                sxc_pkg::OFF_CDW10:   next_st.cdw10 = wr_q;
                sxc_pkg::OFF_CDW11:   next_st.cdw11 = wr_q;
                sxc_pkg::OFF_PTR1_LO: next_st.ptr1[31:0] = wr_q;
                sxc_pkg::OFF_PTR1_HI: next_st.ptr1[63:32] = wr_q;
                sxc_pkg::OFF_PTR2_LO: next_st.ptr2[31:0] = wr_q;
                sxc_pkg::OFF_PTR2_HI: next_st.ptr2[63:32] = wr_q;
                sxc_pkg::OFF_WIN_IDX: next_st.win_idx = wr_q[BUF_AW-1:0];
                sxc_pkg::OFF_CPL:
                    if (wr_q[sxc_pkg::CPL_VALID])
                        next_st.cpl[sxc_pkg::CPL_VALID] = 1'b0;
                sxc_pkg::OFF_WIN_DATA:
                    // Buffer belongs to the engine while a command runs
                    if (st.state == sxc_pkg::SXC_IDLE)
                    begin
                        mem.en = 1'b1;
                        mem.we = 1'b1;
                        mem.wdata = wr_q;
                        next_st.win_idx = st.win_idx + 1'b1;
                    end
                sxc_pkg::OFF_CTRL:
                begin
                    if (wr_q[sxc_pkg::CTRL_DISCARD])
                        next_st.pend_valid = 1'b0;
                    if (wr_q[sxc_pkg::CTRL_GO] && st.state == sxc_pkg::SXC_IDLE)
                    begin
                        next_st.cnt = 32'h0;
                        next_st.code = sxc_pkg::ST_SUCCESS;
                        next_st.disc = 1'b0;
                        next_st.state = sxc_pkg::SXC_POST;
                        case (st.opcode)
                            sxc_pkg::OPC_FORMAT:
                                if (32'(sel_fmt) >= NUM_FORMATS)
                                    next_st.code = sxc_pkg::ST_INV_FMT;
                                else if (st.cdw10[7:5] != 3'b000 &&
                                         meta_of(sel_fmt) < 8'(sxc_pkg::PI_BYTES))
                                    next_st.code = sxc_pkg::ST_INV_FMT;
                                else if (!st.cdw10[sxc_pkg::FMT_MS_BIT] &&
                                         meta_of(sel_fmt) == 8'h00)
                                    next_st.code = sxc_pkg::ST_INV_FMT;
                                else
                                    next_st.state = sxc_pkg::SXC_FMT;
                            sxc_pkg::OPC_SEC_SEND:
                            begin
                                // Only selector, parameter and length are decoded
                                next_st.limit = min32({2'b00, st.cdw11[31:2]} +
                                    {31'h0, |st.cdw11[1:0]}, 32'(BUF_DEPTH));
                                next_st.state = sxc_pkg::SXC_XFER;
                            end
                            sxc_pkg::OPC_SEC_RECV:
                                if (!proto_ok(sel_proto))
                                    next_st.code = sxc_pkg::ST_INV_PARAM;
                                else if (sel_proto == sxc_pkg::PROTO_DISC)
                                begin
                                    next_st.disc = 1'b1;
                                    next_st.limit = min32({2'b00, st.cdw11[31:2]},
                                                          32'(NUM_PROTO + 2));
                                    next_st.state = sxc_pkg::SXC_XFER;
                                end
                                else if (st.pend_valid && st.pend_proto == sel_proto &&
                                         st.pend_protocol_specific_param == st.cdw10[23:8])
                                begin
                                    next_st.limit = min32({2'b00, st.cdw11[31:2]},
                                                          st.pend_len);
                                    next_st.state = sxc_pkg::SXC_XFER;
                                end
                                else
                                    next_st.limit = 32'h0;
                            default:
                                next_st.code = sxc_pkg::ST_INV_PARAM;
                        endcase
                    end
                end
                default:
                    next_st.bresp = 2'b00;
            endcase
        end

        // Register read: stage 1 addresses the buffer, stage 2 loads rdata
        if (s_arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.ar_addr = s_araddr;
            next_st.rd_stage = 2'd1;
        end
        if (st.rd_stage == 2'd1)
        begin
            if (!mem.we)
            begin
                mem.en = 1'b1;
                mem.addr = st.win_idx;
            end
            next_st.rd_stage = 2'd2;
        end
        if (st.rd_stage == 2'd2)
        begin
            next_st.rdata = rd_mux;
            next_st.rvalid = 1'b1;
            next_st.rd_stage = 2'd0;
            if (st.ar_addr == sxc_pkg::OFF_WIN_DATA && st.state == sxc_pkg::SXC_IDLE && !wr_fire)
                next_st.win_idx = st.win_idx + 1'b1;
        end
        if (st.rvalid && s_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        case (st.state)
            // Keep whatever the start decode above chose
            sxc_pkg::SXC_IDLE:
                next_st.state = next_st.state;
            sxc_pkg::SXC_FMT:
            begin
                next_st.cnt = st.cnt + 32'h1;
                if (st.cnt == 32'(sxc_pkg::FORMAT_CYCLES - 1))
                    next_st.state = sxc_pkg::SXC_POST;
            end
            sxc_pkg::SXC_XFER:
                if (st.cnt >= st.limit)
                begin
                    next_st.state = sxc_pkg::SXC_POST;
                    if (st.opcode == sxc_pkg::OPC_SEC_SEND)
                    begin
                        // Results wait for a matching receive
                        next_st.pend_valid = 1'b1;
                        next_st.pend_proto = sel_proto;
                        next_st.pend_protocol_specific_param = st.cdw10[23:8];
                        next_st.pend_len = st.limit;
                    end
                    else if (!st.disc)
                        next_st.pend_valid = 1'b0;
                end
                else
                begin
                    // Second pointer taken as a plain page address
                    next_st.last_addr = seg_addr(st.ptr1, st.ptr2,
                                                 {st.cnt[29:0], 2'b00});
                    next_st.cnt = st.cnt + 32'h1;
                    if (st.disc)
                    begin
                        mem.en = 1'b1;
                        mem.we = 1'b1;
                        mem.addr = st.cnt[BUF_AW-1:0];
                        mem.wdata = (st.cnt == 32'h0) ? 32'(NUM_PROTO + 1) :
                            ((st.cnt == 32'h1) ? 32'h0 :
                            {24'h0, PROTO_LIST[st.cnt[5:0]*8 - 16 +: 8]});
                    end
                end
            sxc_pkg::SXC_POST:
            begin
                // Set beats a software clear in the same cycle
                next_st.cpl = {1'b1, 7'h0, st.opcode, 8'h0, st.code};
                next_st.state = sxc_pkg::SXC_IDLE;
            end
            default:
                next_st.state = sxc_pkg::SXC_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.state <= sxc_pkg::SXC_IDLE;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign s_awready = st.awready;
    assign s_wready  = st.wready;
    assign s_bvalid  = st.bvalid;
    assign s_bresp   = st.bresp;
    assign s_arready = st.arready;
    assign s_rvalid  = st.rvalid;
    assign s_rdata   = st.rdata;
    assign s_rresp   = 2'b00;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic go_now;
    assign go_now = wr_fire && st.aw_addr == sxc_pkg::OFF_CTRL && wr_q[sxc_pkg::CTRL_GO] &&
                    st.state == sxc_pkg::SXC_IDLE;

    fmt_wait_a: assert property ($rose(st.cpl[31]) && st.cpl[7:0] == sxc_pkg::ST_SUCCESS &&
        st.cpl[23:16] == sxc_pkg::OPC_FORMAT |-> $past(st.state, 2) == sxc_pkg::SXC_FMT)
        else $error("format completed early");
    bad_fmt_a: assert property (go_now && st.opcode == sxc_pkg::OPC_FORMAT &&
        32'(sel_fmt) >= NUM_FORMATS |-> ##2 st.cpl[31] && st.cpl[7:0] == sxc_pkg::ST_INV_FMT)
        else $error("bad format number not reported");
    pi_meta_a: assert property (go_now && st.opcode == sxc_pkg::OPC_FORMAT &&
        32'(sel_fmt) < NUM_FORMATS && st.cdw10[7:5] != 3'b000 && meta_of(sel_fmt) < 8'h08
        |-> ##2 st.cpl[7:0] == sxc_pkg::ST_INV_FMT) else $error("short metadata accepted");
    sep_meta_a: assert property (go_now && st.opcode == sxc_pkg::OPC_FORMAT &&
        32'(sel_fmt) < NUM_FORMATS && st.cdw10[7:5] == 3'b000 && !st.cdw10[4] &&
        meta_of(sel_fmt) == 8'h00 |-> ##2 st.cpl[7:0] == sxc_pkg::ST_INV_FMT)
        else $error("separate metadata accepted");
    bad_proto_a: assert property (go_now && st.opcode == sxc_pkg::OPC_SEC_RECV &&
        !proto_ok(sel_proto) |-> ##2 st.cpl[31] && st.cpl[7:0] == sxc_pkg::ST_INV_PARAM)
        else $error("unsupported protocol accepted");
    disc_keep_a: assert property (st.state == sxc_pkg::SXC_XFER && st.disc |=>
        st.pend_valid == $past(st.pend_valid)) else $error("discovery touched pending data");
    page_two_a: assert property (st.state == sxc_pkg::SXC_XFER && st.cnt < st.limit &&
        {st.cnt[29:0], 2'b00} >= 32'(4096) - {20'h0, st.ptr1[11:0]} |=>
        st.last_addr == $past(st.ptr2) + 64'($past({st.cnt[29:0], 2'b00})) +
        64'($past(st.ptr1[11:0])) - 64'(4096))
        else $error("second segment not from pointer two");
    post_cpl_a: assert property (st.state == sxc_pkg::SXC_POST |=> st.cpl[31] &&
        st.state == sxc_pkg::SXC_IDLE) else $error("completion not posted");
    send_pend_a: assert property (st.state == sxc_pkg::SXC_XFER && st.cnt >= st.limit &&
        st.opcode == sxc_pkg::OPC_SEC_SEND |=> st.pend_valid && st.pend_proto == sel_proto)
        else $error("send not paired");

    fmt_run_c: cover property (st.state == sxc_pkg::SXC_FMT ##1 st.state == sxc_pkg::SXC_POST);
    disc_c: cover property (st.disc && st.state == sxc_pkg::SXC_POST);
    pair_c: cover property (st.pend_valid ##[1:300] !st.pend_valid && st.cpl[31]);
endmodule

// >>> sxc_host_model.sv
`timescale 1ns/1ps
module sxc_host_model (
    input  wire logic        aclk,
    output logic [7:0]       s_awaddr,
    output logic             s_awvalid,
    input  wire logic        s_awready,
    output logic [31:0]      s_wdata,
    output logic [3:0]       s_wstrb,
    output logic             s_wvalid,
    input  wire logic        s_wready,
    input  wire logic        s_bvalid,
    output logic             s_bready,
    output logic [7:0]       s_araddr,
    output logic             s_arvalid,
    input  wire logic        s_arready,
    input  wire logic [31:0] s_rdata,
    input  wire logic        s_rvalid,
    output logic             s_rready
);
    initial
    begin
        {s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
        s_wstrb = 4'hf;
    end

    // Caller enters just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (s_awvalid && s_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (s_wvalid && s_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        // Idle edge so a following call never re-drives a strobe in this time step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (s_rvalid !== 1'b1);
        d = s_rdata;
        s_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// >>> test_security_xfer_cmd_handler.sv
`timescale 1ns/1ps
module test_security_xfer_cmd_handler;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_awaddr;
    logic        s_awvalid;
    logic        s_awready;
    logic [31:0] s_wdata;
    logic [3:0]  s_wstrb;
    logic        s_wvalid;
    logic        s_wready;
    logic [1:0]  s_bresp;
    logic        s_bvalid;
    logic        s_bready;
    logic [7:0]  s_araddr;
    logic        s_arvalid;
    logic        s_arready;
    logic [31:0] s_rdata;
    logic [1:0]  s_rresp;
    logic        s_rvalid;
    logic        s_rready;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    logic [31:0] v;

    sxc_cmd_handler u_dut (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready)
    );
    sxc_host_model u_host (
        .aclk      (aclk),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready)
    );

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        // Responses are always OKAY; looked at on the handshake edge
        if (s_bvalid === 1'b1 && s_bready === 1'b1)
            chk({30'h0, s_bresp}, 32'h0);
        if (s_rvalid === 1'b1 && s_rready === 1'b1)
            chk({30'h0, s_rresp}, 32'h0);
        if (cyc == 40000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Poll bound covers the long format run
    task automatic cmd(input logic [7:0] opc, input logic [31:0] d10, input logic [31:0] d11);
        int n;
        u_host.wr(sxc_pkg::OFF_OPCODE, {24'h0, opc});
        u_host.wr(sxc_pkg::OFF_CDW10, d10);
        u_host.wr(sxc_pkg::OFF_CDW11, d11);
        // Two dwords before the page break, the rest through pointer two
        u_host.wr(sxc_pkg::OFF_PTR1_LO, 32'h0000_1ff8);
        u_host.wr(sxc_pkg::OFF_PTR2_LO, 32'h0000_3000);
        u_host.wr(sxc_pkg::OFF_CTRL, 32'h0000_0001);
        n = 0;
        v = '0;
        while (v[31] !== 1'b1 && n < 2000)
        begin
            u_host.rd(sxc_pkg::OFF_CPL, v);
            n++;
        end
        u_host.wr(sxc_pkg::OFF_CPL, 32'h8000_0000);
        v = v & 32'h80ff_00ff;
    endtask

    task automatic look(input logic [7:0] a, input logic [31:0] exp);
        u_host.rd(a, v);
        chk(v, exp);
    endtask

    task automatic pend(input logic [31:0] exp);
        u_host.rd(sxc_pkg::OFF_STATUS, v);
        chk(v & 32'h3, exp);
    endtask

    task automatic t_reset();
        pend(32'h0);
        u_host.rd(sxc_pkg::OFF_CPL, v);
        chk(v, 32'h0);
        u_host.rd(8'h40, v);
        chk(v, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_format();
        int start;
        cmd(sxc_pkg::OPC_FORMAT, 32'h12, 0);
        chk(v, 32'h8080_000a);
        cmd(sxc_pkg::OPC_FORMAT, 32'h30, 0);
        chk(v, 32'h8080_000a);
        cmd(sxc_pkg::OPC_FORMAT, 32'h00, 0);
        chk(v, 32'h8080_000a);
        start = cyc;
        cmd(sxc_pkg::OPC_FORMAT, 32'h31, 0);
        chk(v, 32'h8080_0000);
        chk({31'h0, (cyc - start) >= sxc_pkg::FORMAT_CYCLES}, 32'h1);
        $display("test format done");
    endtask

    task automatic t_security();
        cmd(sxc_pkg::OPC_SEC_RECV, 32'h0500_0000, 32'h10);
        chk(v, 32'h8082_0002);
        cmd(sxc_pkg::OPC_SEC_SEND, 32'h0112_3400, 32'h10);
        chk(v, 32'h8081_0000);
        look(sxc_pkg::OFF_ADDR_LO, 32'h0000_3004);
        pend(32'h2);
        cmd(sxc_pkg::OPC_SEC_RECV, 32'h0000_00ff, 32'h40);
        chk(v, 32'h8082_0000);
        pend(32'h2);
        u_host.wr(sxc_pkg::OFF_WIN_IDX, 32'h0);
        look(sxc_pkg::OFF_WIN_DATA, 32'h3);
        look(sxc_pkg::OFF_WIN_DATA, 32'h0);
        look(sxc_pkg::OFF_WIN_DATA, 32'h1);
        look(sxc_pkg::OFF_WIN_DATA, 32'h2);
        cmd(sxc_pkg::OPC_SEC_RECV, 32'h0112_34ff, 32'h0000_0010);
        chk(v, 32'h8082_0000);
        look(sxc_pkg::OFF_ADDR_LO, 32'h0000_3004);
        pend(32'h0);
        cmd(sxc_pkg::OPC_SEC_SEND, 32'h0200_0000, 32'h10);
        pend(32'h2);
        u_host.wr(sxc_pkg::OFF_CTRL, 32'h0000_0002);
        pend(32'h0);
        cmd(sxc_pkg::OPC_SEC_SEND, 32'h0200_0000, 32'h10);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        pend(32'h0);
        $display("test security done");
    endtask

    initial
    begin
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_format();
        t_security();
        give_verdict();
    end
endmodule
